// file: szt_pkg.sv
// Constants for the static zone timing configuration block
package szt_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [15:0] ZONE0_CFG_ADDR  = 16'hF904;
    localparam logic [15:0] ZONE1_CFG_ADDR  = 16'hF906;
    localparam logic [15:0] ZONE_CFG_RESET  = 16'h069F;
    localparam logic [15:0] ZONE_CFG_MASK   = 16'h0E9F;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int WAIT_LSB       = 0;
    localparam int WAIT_MSB       = 2;
    localparam int HOLD_LSB       = 3;
    localparam int HOLD_MSB       = 4;
    localparam int BUS_WIDTH_BIT  = 7;
    localparam int POST_IDLE_BIT  = 9;
    localparam int PRE_IDLE_BIT   = 10;
    localparam int FAST_READ_BIT  = 11;

    // ************************************************************
    // Bus cycle phases
    // ************************************************************
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_ZIDLE = 3'b001,
        PH_ADDR  = 3'b010,
        PH_WAIT  = 3'b011,
        PH_DATA  = 3'b100,
        PH_HOLD  = 3'b101
    } szt_phase_t;
endpackage

// file: szt_cycle_if.sv
// Carrier between zone configuration logic and bus cycle sequencer
`timescale 1ns/10ps
interface szt_cycle_if;
    logic       start;
    logic [1:0] idleCount;
    logic [2:0] waitCount;
    logic [1:0] holdCount;
    logic       fastRead;
    logic       busy;
    logic       done;
    szt_pkg::szt_phase_t phase;

    modport ctrl (output start, idleCount, waitCount, holdCount, fastRead,
                  input busy, done, phase);
    modport seq  (input start, idleCount, waitCount, holdCount, fastRead,
                  output busy, done, phase);
endinterface

// file: szt_cycle_seq.sv
// Bus cycle sequencer: zone-change idles, address, waits, data, holds
`timescale 1ns/10ps
module szt_cycle_seq
(
    // Clock, reset and enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Cycle carrier
    szt_cycle_if.seq cyc
);
    szt_pkg::szt_phase_t phase;
    szt_pkg::szt_phase_t next_phase;
    logic [2:0]          count;
    logic [2:0]          next_count;
    logic [2:0]          waitLeft;
    logic [1:0]          holdLeft;

    // Phase outputs for the user side
    assign cyc.phase = phase;
    assign cyc.busy  = (phase != szt_pkg::PH_IDLE);
    assign cyc.done  = ((phase == szt_pkg::PH_DATA) && (holdLeft == 2'b00))
                     || ((phase == szt_pkg::PH_HOLD) && (count == 3'b001));

    // Phase sequencing
    always_comb
    begin
        next_phase = phase;
        next_count = count;
        case (phase)
            szt_pkg::PH_IDLE:
            begin
                if (cyc.start && (cyc.idleCount != 2'b00))
                begin
                    next_phase = szt_pkg::PH_ZIDLE;
                    next_count = {1'b0, cyc.idleCount};
                end
                else if (cyc.start && cyc.fastRead)
                    next_phase = szt_pkg::PH_DATA;       // One-cycle read [RULE8]
                else if (cyc.start)
                    next_phase = szt_pkg::PH_ADDR;
            end
            szt_pkg::PH_ZIDLE:
            begin
                next_count = count - 3'b001;
                if (count == 3'b001)
                    next_phase = cyc.fastRead ? szt_pkg::PH_DATA : szt_pkg::PH_ADDR;
            end
            szt_pkg::PH_ADDR:
            begin
                // Waits follow the address phase [RULE14]
                next_count = waitLeft;
                next_phase = (waitLeft != 3'b000) ? szt_pkg::PH_WAIT : szt_pkg::PH_DATA;
            end
            szt_pkg::PH_WAIT:
            begin
                next_count = count - 3'b001;
                if (count == 3'b001)
                    next_phase = szt_pkg::PH_DATA;
            end
            szt_pkg::PH_DATA:
            begin
                // Holds close the cycle, data kept on the bus [RULE15]
                next_count = {1'b0, holdLeft};
                next_phase = (holdLeft != 2'b00) ? szt_pkg::PH_HOLD : szt_pkg::PH_IDLE;
            end
            szt_pkg::PH_HOLD:
            begin
                next_count = count - 3'b001;
                if (count == 3'b001)
                    next_phase = szt_pkg::PH_IDLE;
            end
            default:
            begin
                next_phase = szt_pkg::PH_IDLE;
                next_count = 3'b000;
            end
        endcase
    end

    // Captured wait and hold counts for the running cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitLeft <= 3'h0;
            holdLeft <= 2'h0;
        end
        else if (ce && (phase == szt_pkg::PH_IDLE) && cyc.start)
        begin
            waitLeft <= cyc.fastRead ? 3'h0 : cyc.waitCount;   // [RULE5]
            holdLeft <= cyc.fastRead ? 2'h0 : cyc.holdCount;   // [RULE5]
        end
    end

    // State registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase <= szt_pkg::PH_IDLE;
            count <= 3'h0;
        end
        else if (ce)
        begin
            phase <= next_phase;
            count <= next_count;
        end
    end
endmodule // szt_cycle_seq

// file: szt_zone_timing.sv
// Static zone timing registers and bus cycle control for two zones
// Function
// RULE1 - Zone 0 register at F904, reset 069F
// RULE2 - Zone 1 register at F906, reset 069F
// RULE3 - Wait field adds zero to seven waits
// RULE4 - Hold field appends zero to three holds
// RULE5 - Fast read makes wait, hold ignored
// RULE6 - Bus width bit: 0 byte, 1 word
// RULE7 - Software keeps bus width at word
// RULE8 - Fast read one cycle, normal two plus
// RULE9 - Post idle on zone change after cycle
// RULE10 - Pre idle on zone change before cycle
// RULE11 - Software may clear both idle bits
// RULE12 - Software writes zeros to reserved bits
// RULE13 - Zone 0 flash, zone 1 boot ROM
// RULE14 - Waits follow the address phase
// RULE15 - Holds at end, data kept
// RULE16 - Flash normal read: one plus wait; code takes two plus wait
// RULE17 - Low byte: width 7, hold 4:3, wait 2:0
// RULE18 - Read returns written fields, reserved zero
`timescale 1ns/10ps
module szt_zone_timing
(
    // Clock, reset and enable
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Register port
    input  wire logic [15:0] regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [15:0] regWdata,
    output logic      [15:0] regRdata,
    // Bus cycle request
    input  wire logic        reqValid,
    input  wire logic        reqZone,
    input  wire logic        reqWrite,
    output logic             reqReady,
    // Bus cycle progress
    output logic             cycAddr,
    output logic             cycWait,
    output logic             cycData,
    output logic             cycHold,
    output logic             cycIdle,
    output logic             cycDone,
    output logic             cycWide,
    // Configuration view
    output logic             zone0Wide,
    output logic             zone1Wide
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [15:0] zone0_timing_config;
    logic [15:0] zone1_timing_config;
    logic        lastZone;
    logic        lastValid;
    logic        activeZone;
    logic        activeWrite;

    szt_cycle_if cyc ();

    // Field extraction shared by both zones
    function automatic logic [2:0] waitOf(input logic [15:0] cfg);
        waitOf = cfg[szt_pkg::WAIT_MSB:szt_pkg::WAIT_LSB];
    endfunction

    function automatic logic [1:0] holdOf(input logic [15:0] cfg);
        holdOf = cfg[szt_pkg::HOLD_MSB:szt_pkg::HOLD_LSB];
    endfunction

    // ************************************************************
    // Register decode
    // ************************************************************
    wire         hit0     = (regAddr == szt_pkg::ZONE0_CFG_ADDR);   // [RULE1]
    wire         hit1     = (regAddr == szt_pkg::ZONE1_CFG_ADDR);   // [RULE2]
    wire  [15:0] wdMasked = regWdata & szt_pkg::ZONE_CFG_MASK;      // [RULE12] [RULE18]
    wire  [15:0] rdSel    = hit0 ? zone0_timing_config
                          : hit1 ? zone1_timing_config : 16'h0000;

    // Register storage
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zone0_timing_config <= szt_pkg::ZONE_CFG_RESET;         // [RULE1]
            zone1_timing_config <= szt_pkg::ZONE_CFG_RESET;         // [RULE2]
        end
        else if (ce && regWrite)
        begin
            if (hit0)
                zone0_timing_config <= wdMasked;
            if (hit1)
                zone1_timing_config <= wdMasked;
        end
    end

    // Registered read data, zero for unmapped addresses
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            regRdata <= 16'h0000;
        else if (ce && regRead)
            regRdata <= rdSel;                                      // [RULE18]
    end

    // ************************************************************
    // Zone selection and cycle request
    // ************************************************************
    // Zone 0 serves flash, zone 1 serves boot ROM
    wire  [15:0] reqCfg    = reqZone ? zone1_timing_config : zone0_timing_config; // [RULE13]
    wire  [15:0] lastCfg   = lastZone ? zone1_timing_config : zone0_timing_config;
    wire         reqFast   = reqCfg[szt_pkg::FAST_READ_BIT];
    wire         zoneSwap  = lastValid && (lastZone != reqZone);
    wire         postIdle  = zoneSwap && lastCfg[szt_pkg::POST_IDLE_BIT];   // [RULE9]
    wire         preIdle   = zoneSwap && reqCfg[szt_pkg::PRE_IDLE_BIT];     // [RULE10]
    wire  [2:0]  waitNorm  = waitOf(reqCfg);                                // [RULE3] [RULE16]
    wire  [2:0]  waitFastW = 3'b001;

    // Carrier drive toward the sequencer
    assign reqReady      = !cyc.busy;
    assign cyc.start     = reqValid && reqReady && ce;
    assign cyc.idleCount = {1'b0, postIdle} + {1'b0, preIdle};
    assign cyc.fastRead  = reqFast && !reqWrite;                   // [RULE8]
    assign cyc.waitCount = (reqFast && reqWrite) ? waitFastW : waitNorm;
    assign cyc.holdCount = (reqFast && reqWrite) ? 2'b00 : holdOf(reqCfg); // [RULE4] [RULE5]

    // Remember the zone of each accepted cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lastZone    <= 1'b0;
            lastValid   <= 1'b0;
            activeZone  <= 1'b0;
            activeWrite <= 1'b0;
        end
        else if (cyc.start)
        begin
            lastZone    <= reqZone;
            lastValid   <= 1'b1;
            activeZone  <= reqZone;
            activeWrite <= reqWrite;
        end
    end

    // ************************************************************
    // Sequencer and progress outputs
    // ************************************************************
    szt_cycle_seq u_seq
    (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .cyc   (cyc.seq)
    );

    assign cycAddr   = (cyc.phase == szt_pkg::PH_ADDR);
    assign cycWait   = (cyc.phase == szt_pkg::PH_WAIT);
    assign cycData   = (cyc.phase == szt_pkg::PH_DATA);
    assign cycHold   = (cyc.phase == szt_pkg::PH_HOLD);
    assign cycIdle   = (cyc.phase == szt_pkg::PH_ZIDLE);
    assign cycDone   = cyc.done;
    // Bus width of the running zone, software keeps it at word [RULE6] [RULE7]
    assign cycWide   = activeZone ? zone1Wide : zone0Wide;
    assign zone0Wide = zone0_timing_config[szt_pkg::BUS_WIDTH_BIT];         // [RULE17]
    assign zone1Wide = zone1_timing_config[szt_pkg::BUS_WIDTH_BIT];
endmodule // szt_zone_timing

// file: szt_zone_timing_props.sv
// Concurrent checks on the zone timing block ports
`timescale 1ns/10ps
module szt_zone_timing_props
(
    // Clock, reset and enable
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        ce,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    // Bus cycle
    input wire logic        reqValid,
    input wire logic        reqZone,
    input wire logic        reqWrite,
    input wire logic        reqReady,
    input wire logic        cycAddr,
    input wire logic        cycWait,
    input wire logic        cycData,
    input wire logic        cycHold,
    input wire logic        cycIdle,
    input wire logic        cycDone,
    input wire logic        cycWide,
    input wire logic        zone0Wide,
    input wire logic        zone1Wide
);
    // ****
    // Mirror of the two registers
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [15:0] cfg0;
    logic [15:0] cfg1;
    // Decodes of address and selected zone
    wire         hit0   = regAddr == szt_pkg::ZONE0_CFG_ADDR;
    wire         hit1   = regAddr == szt_pkg::ZONE1_CFG_ADDR;
    wire  [15:0] rdExp  = hit0 ? cfg0 : cfg1;
    wire  [15:0] cfgZ   = reqZone ? cfg1 : cfg0;
    wire         takeRd = reqValid && reqReady && ce && !reqWrite;
    logic        zoneR;
    // Zone of the last accepted bus cycle
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            zoneR <= 1'b0;
        else if (reqValid && reqReady && ce)
            zoneR <= reqZone;
    // Writable fields only, reserved kept zero
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
        begin
            cfg0 <= szt_pkg::ZONE_CFG_RESET;
            cfg1 <= szt_pkg::ZONE_CFG_RESET;
        end
        else if (ce && regWrite)
        begin
            if (hit0) cfg0 <= regWdata & szt_pkg::ZONE_CFG_MASK;
            if (hit1) cfg1 <= regWdata & szt_pkg::ZONE_CFG_MASK;
        end
    // Read taken with no idle cycle ahead
    sequence s_fast;
        takeRd && cfgZ[szt_pkg::FAST_READ_BIT] ##1 !cycIdle;
    endsequence
    sequence s_base;
        takeRd && !cfgZ[11] && cfgZ[4:0] == 5'h00 ##1 !cycIdle;
    endsequence
    sequence s_seven;
        takeRd && !cfgZ[11] && cfgZ[4:0] == 5'h07 ##1 !cycIdle;
    endsequence
    AST_RD_MAP: assert property (regRead && ce && (hit0 || hit1) |=> regRdata == $past(rdExp))
        else $error("register read value wrong");
    AST_WIDTH: assert property (zone0Wide == cfg0[7] && zone1Wide == cfg1[7])
        else $error("bus width view wrong");
    AST_RUN_WIDTH: assert property (cycWide == (zoneR ? cfg1[7] : cfg0[7]))
        else $error("running zone width wrong");
    AST_WAIT_POS: assert property (cycWait |-> $past(cycAddr) || $past(cycWait))
        else $error("wait not after address");
    AST_HOLD_POS: assert property (cycHold |-> $past(cycData) || $past(cycHold))
        else $error("hold not after data");
    AST_FAST_READ: assert property (s_fast |-> cycData && cycDone)
        else $error("fast read not one cycle");
    AST_BASE_READ: assert property (s_base |-> cycAddr ##1 cycData && cycDone)
        else $error("base read not two cycles");
    AST_SEVEN_WAIT: assert property (s_seven |-> cycAddr ##1 cycWait [*7] ##1 cycData && cycDone)
        else $error("seven waits not inserted");
    AST_NO_IDLE: assert property (takeRd && {cfg0[10:9], cfg1[10:9]} == 4'h0 |=> !cycIdle)
        else $error("idle inserted while disabled");
endmodule // szt_zone_timing_props

bind szt_zone_timing szt_zone_timing_props szt_zone_timing_props_inst (.*);

// file: szt_cpu_model.sv
// CPU model issuing register accesses and bus cycles
`timescale 1ns/10ps
module szt_cpu_model
(
    // Clock
    input  wire logic        clock,
    // Register port
    output logic      [15:0] regAddr,
    output logic             regWrite,
    output logic             regRead,
    output logic      [15:0] regWdata,
    input  wire logic [15:0] regRdata,
    // Bus cycle
    output logic             reqValid,
    output logic             reqZone,
    output logic             reqWrite,
    input  wire logic        reqReady,
    input  wire logic        cycDone
);
    // ****
    // Access tasks
    // ****
    initial {regAddr, regWrite, regRead, regWdata, reqValid, reqZone, reqWrite} = '0;
    // One register cycle; released address and data show inverted values, strobes low
    task automatic reg_op(input logic w, input logic [15:0] a, d, output logic [15:0] q);
        @(posedge clock) #2;
        {regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
        @(posedge clock) #2;
        {regWrite, regRead, regAddr, regWdata} = {2'b00, ~a, ~d};
        q = regRdata;
    endtask
    // Request held until taken, then cycles counted up to done
    task automatic bus_op(input logic z, w, output int n);
        @(posedge clock) #2;
        {reqValid, reqZone, reqWrite} = {1'b1, z, w};
        for (n = 0; n < 40 && reqReady !== 1'b1; n++) @(posedge clock) #2;
        @(posedge clock) #2;
        {reqValid, reqZone, reqWrite} = {1'b0, ~z, ~w};
        for (n = 1; n < 40 && cycDone !== 1'b1; n++) @(posedge clock) #2;
    endtask
endmodule // szt_cpu_model

// file: static_zone_bus_timing_config_bench.sv
// Self-checking bench for the zone timing block
`timescale 1ns/10ps
module static_zone_bus_timing_config_bench;
    // ****
    // Wiring and bookkeeping
    // ****
    typedef struct packed {logic z; logic w; logic [15:0] cfg; logic [7:0] len;} szt_row_t;
    logic        clock;
    logic        rst_n;
    logic [15:0] regAddr, regWdata, regRdata, q;
    logic        regWrite, regRead, reqValid, reqZone, reqWrite, reqReady, cycDone;
    int          numErrors, testsRun, cycles, n;
    // Zone, write, config, expected cycle count
    szt_row_t    rows [6] = '{
        '{1'b0, 1'b0, 16'h0080, 8'h02},
        '{1'b1, 1'b0, 16'h0087, 8'h09},
        '{1'b0, 1'b0, 16'h0098, 8'h05},
        '{1'b1, 1'b0, 16'h089F, 8'h01},
        '{1'b0, 1'b1, 16'h089F, 8'h03},
        '{1'b1, 1'b1, 16'h009F, 8'h0C}};
    szt_zone_timing szt_zone_timing_inst (.*, .ce(1'b1), .cycAddr(), .cycWait(), .cycData(),
        .cycHold(), .cycIdle(), .cycWide(), .zone0Wide(), .zone1Wide());
    szt_cpu_model szt_cpu_model_inst (.*);
    // Compare and report
    task automatic chk(input logic [15:0] got, exp);
        testsRun++;
        if (got !== exp)
        begin
            numErrors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, d);
        szt_cpu_model_inst.reg_op(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [15:0] a, e);
        szt_cpu_model_inst.reg_op(1'b0, a, 16'h0000, q);
        chk(q, e);
    endtask
    task automatic bus(input logic z, w, input logic [7:0] e);
        szt_cpu_model_inst.bus_op(z, w, n);
        chk(16'(n), {8'h00, e});
    endtask
    task automatic closeOut();
        if (numErrors == 0 && testsRun > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Clock
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            numErrors++;
            closeOut();
        end
    end
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        repeat (3) @(posedge clock);
        #2 rst_n = 1'b1;
        wr(16'hF904, 16'h0080);
        wr(16'hF906, 16'h0080);
        foreach (rows[i])
        begin
            wr(rows[i].z ? 16'hF906 : 16'hF904, rows[i].cfg);
            rd(rows[i].z ? 16'hF906 : 16'hF904, rows[i].cfg);
            bus(rows[i].z, rows[i].w, rows[i].len);
        end
        // Reserved bits and unmapped address
        wr(16'hF904, 16'hFFFF);
        rd(16'hF904, 16'h0E9F);
        wr(16'hF908, 16'h1234);
        rd(16'hF908, 16'h0000);
        wr(16'hF906, 16'h0000);
        rd(16'hF906, 16'h0000);
        // Second reset, then idles at zone change
        @(posedge clock) #2 rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #2 rst_n = 1'b1;
        rd(16'hF904, 16'h069F);
        rd(16'hF906, 16'h069F);
        bus(1'b0, 1'b0, 8'd12);
        bus(1'b1, 1'b0, 8'd14);
        wr(16'hF904, 16'h0080);
        bus(1'b0, 1'b0, 8'd3);
        closeOut();
    end
endmodule // static_zone_bus_timing_config_bench
